// >>> logic/transport_pkg.sv
// shared constants and types for the tape transport mode controller
package transport_pkg;
    // bus data width
    localparam int DATA_W = 32;
    // register byte offsets
    localparam logic [11:0] CTRL_OFF = 12'h000;
    localparam logic [11:0] THRESH_OFF = 12'h004;
    localparam logic [11:0] COUNT_OFF = 12'h008;
    localparam logic [11:0] STATUS_OFF = 12'h00c;
    localparam logic [11:0] SERVO_OFF = 12'h010;
    // control field positions
    localparam int CTRL_ARP_BIT = 0;
    localparam int CTRL_MEM_BIT = 1;
    localparam int CTRL_MEMPLAY_BIT = 2;
    localparam int CTRL_CAL_BIT = 3;
    localparam int CTRL_AREV_BIT = 4;
    localparam int CTRL_W = 5;
    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
    localparam logic [15:0] THRESH_RST = 16'h0100;
    // clock and timing
    localparam int CLK_HZ = 10_000_000;
    localparam int SILENCE_S = 30;
    localparam int SILENCE_CYC = SILENCE_S * CLK_HZ;
    localparam int FADE_SLOW_S = 6;
    localparam int FADE_FAST_S = 2;
    localparam int FADE_STEPS = 256;
    localparam int FADE_SLOW_CYC = FADE_SLOW_S * CLK_HZ / FADE_STEPS;
    localparam int FADE_FAST_CYC = FADE_FAST_S * CLK_HZ / FADE_STEPS;
    localparam int HOLD_MS = 500;
    localparam int HOLD_CYC = HOLD_MS * (CLK_HZ / 1000);
    // speed codes in units of one-sixth of normal
    localparam logic [3:0] SPD_STOP = 4'h0;
    localparam logic [3:0] SPD_SIXTH = 4'h1;
    localparam logic [3:0] SPD_NORMAL = 4'h6;
    localparam logic [3:0] SPD_FAST = 4'hc;
    localparam logic [3:0] SPD_CUE = 4'h8;
    // counter span
    localparam logic signed [15:0] CNT_MIN = -16'sd999;
    localparam logic signed [15:0] CNT_MAX = 16'sd9999;
    // meter sensitivity gains in dB
    localparam logic [4:0] METER_BOOST_DB = 5'h14;
    // servo position width
    localparam int POS_W = 8;
    // transport modes, gray along stop-play-record path
    typedef enum logic [2:0] {
        M_STOP = 3'b000,
        M_PLAY = 3'b001,
        M_REC = 3'b011,
        M_PAUSE = 3'b010,
        M_FFWD = 3'b110,
        M_REW = 3'b111
    } mode_t;
    // head cam positions per mode
    function automatic logic [7:0] cam_target(input mode_t m, input logic cue);
        unique case (m)
            M_PLAY, M_REC: cam_target = 8'hc0;
            M_PAUSE: cam_target = 8'h80;
            M_FFWD, M_REW: cam_target = cue ? 8'h60 : 8'h20;
            default: cam_target = 8'h00;
        endcase
    endfunction
endpackage

// >>> logic/fade_ramp.sv
// stepped record-level fade generator
`timescale 1ns/1ps
module fade_ramp
    import transport_pkg::*;
#(
    parameter int SLOW_CYC = FADE_SLOW_CYC,
    parameter int FAST_CYC = FADE_FAST_CYC
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic start_up,
    input wire logic start_down,
    input wire logic fast,
    output logic [7:0] gain,
    output logic busy
);
    logic [23:0] tick_reg; // cycles left in current step
    logic dir_reg; // 1 ramps up
    logic fast_reg; // held-key speed latched
    logic [23:0] step_len;
    // step length from selected duration
    assign step_len = fast_reg ? 24'(FAST_CYC - 1) : 24'(SLOW_CYC - 1);
    // monotonic steps at the 6 s rate, switching to the 2 s rate once the key is held
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            gain <= 8'hff;
            busy <= 1'b0;
            dir_reg <= 1'b0;
            fast_reg <= 1'b0;
            tick_reg <= 24'h000000;
        end else if (start_up || start_down) begin
            busy <= 1'b1;
            dir_reg <= start_up;
            fast_reg <= 1'b0;
            gain <= start_up ? 8'h00 : 8'hff;
            tick_reg <= 24'(SLOW_CYC - 1);
        end else if (busy) begin
            if (fast) begin
                fast_reg <= 1'b1; // key still held, speed up
            end
            if (tick_reg == 24'h000000) begin
                tick_reg <= step_len;
                if (dir_reg && gain != 8'hff) begin
                    gain <= gain + 8'h01;
                end else if (!dir_reg && gain != 8'h00) begin
                    gain <= gain - 8'h01;
                end else begin
                    busy <= 1'b0;
                end
            end else begin
                tick_reg <= tick_reg - 24'h000001;
            end
        end
    end
    // gain never falls while fading up
    a_fade_monotonic: assert property (@(posedge clock) disable iff (sys_rst)
        busy && !$rose(busy) && dir_reg |=> gain >= $past(gain))
        else $error("fade up went down");
endmodule

// >>> logic/transport_ctrl.sv
// tape transport supervisory mode controller with apb registers
`timescale 1ns/1ps
module transport_ctrl
    import transport_pkg::*;
#(
    parameter int SILENCE_LIMIT = SILENCE_CYC,
    parameter int HOLD_LIMIT = HOLD_CYC,
    parameter int SLOW_CYC = FADE_SLOW_CYC,
    parameter int FAST_CYC = FADE_FAST_CYC
) (
    input wire logic clock,
    input wire logic sys_rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // panel keys, level while pressed
    input wire logic key_play,
    input wire logic key_rec,
    input wire logic key_stop,
    input wire logic key_pause,
    input wire logic key_ffwd,
    input wire logic key_rew,
    input wire logic key_cue,
    input wire logic key_fade_up,
    input wire logic key_fade_down,
    input wire logic key_mute,
    // remote keys
    input wire logic rem_play,
    input wire logic rem_rec,
    input wire logic rem_pause,
    // program level and tape sensing
    input wire logic [15:0] input_level,
    input wire logic counter_pulse,
    input wire logic tape_end,
    input wire logic [7:0] cam_position,
    // outputs
    output logic [3:0] capstan_speed,
    output logic capstan_reverse,
    output logic cam_drive_en,
    output logic cam_drive_dir,
    output logic head_near,
    output logic rec_mute,
    output logic [7:0] rec_gain,
    output logic [4:0] meter_boost_db,
    output logic signed [15:0] tape_counter
);
    mode_t mode_reg; // transport mode
    logic cue_reg; // cue active
    logic slow_reg; // sixth speed while held
    logic [CTRL_W-1:0] ctrl_reg; // control bits
    logic [15:0] thresh_reg; // silence threshold
    logic [31:0] silence_reg; // silence cycle count
    logic [31:0] hold_reg; // fade key hold count
    logic remote_mute_reg; // latched remote mute
    logic prev_keys_reg; // any key last cycle
    logic [7:0] fade_gain;
    logic fade_busy;
    logic fade_fast;
    logic apb_wr;
    logic [7:0] cam_goal; // servo set point for the mode
    logic tape_rise; // end of tape seen once
    logic any_key;
    logic wind;
    logic cue_press;
    logic at_zero;
    logic rec_tap_rem;
    logic prev_rem_rec_reg; // remote record last cycle
    logic prev_fade_reg; // fade key last cycle
    logic prev_tape_reg; // tape end last cycle

    assign wind = (mode_reg == M_FFWD) || (mode_reg == M_REW);
    // remote pause doubles as cue in wind
    assign cue_press = key_cue || (wind && rem_pause);
    assign at_zero = (tape_counter == 16'sd0);
    assign any_key = key_play | key_rec | key_stop | key_pause | key_ffwd | key_rew | cue_press | rem_play | rem_rec;
    assign rec_tap_rem = rem_rec && !prev_rem_rec_reg;
    assign apb_wr = psel && penable && pwrite && pready; // lands as pready is sampled
    assign tape_rise = tape_end && !prev_tape_reg; // a held end-of-tape level acts once
    assign cam_goal = cam_target(mode_reg, cue_reg);

    // edge memories for keys and tape end
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            prev_keys_reg <= 1'b0;
            prev_rem_rec_reg <= 1'b0;
            prev_fade_reg <= 1'b0;
            prev_tape_reg <= 1'b0;
        end else begin
            prev_keys_reg <= any_key;
            prev_rem_rec_reg <= rem_rec;
            prev_fade_reg <= key_fade_up | key_fade_down;
            prev_tape_reg <= tape_end;
        end
    end

    // transport mode sequencing
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            mode_reg <= M_STOP;
            cue_reg <= 1'b0;
        end else if ((mode_reg == M_REC) && ctrl_reg[CTRL_ARP_BIT] && silence_reg >= 32'(SILENCE_LIMIT)) begin
            mode_reg <= M_PAUSE; // silence timeout pauses
        end else if (wind && ctrl_reg[CTRL_MEM_BIT] && at_zero) begin
            mode_reg <= ctrl_reg[CTRL_MEMPLAY_BIT] ? M_PLAY : M_STOP; // memory stop
            cue_reg <= 1'b0;
        end else if (tape_rise && (mode_reg == M_PLAY) && !ctrl_reg[CTRL_AREV_BIT]) begin
            mode_reg <= M_STOP;
        end else if (any_key && !prev_keys_reg) begin
            if (key_stop) begin
                mode_reg <= M_STOP;
                cue_reg <= 1'b0;
            end else if ((key_play || rem_play) && (key_rec || rem_rec)) begin
                if (mode_reg == M_PLAY) begin
                    mode_reg <= M_REC; // punch-in from play only, in either capstan direction
                end
            end else if (cue_press && wind) begin
                cue_reg <= 1'b1; // cue engages
            end else if (key_ffwd && !cue_reg) begin
                mode_reg <= M_FFWD;
            end else if (key_rew && !cue_reg) begin
                mode_reg <= M_REW;
            end else if (key_play || rem_play) begin
                mode_reg <= M_PLAY;
                cue_reg <= 1'b0;
            end else if (key_pause && mode_reg == M_REC) begin
                mode_reg <= M_PAUSE;
            end
        end
    end

    // sixth speed for as long as wind key held in cue
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            slow_reg <= 1'b0;
        end else begin
            slow_reg <= cue_reg && wind && (key_ffwd || key_rew);
        end
    end

    // capstan speed and direction
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            capstan_speed <= SPD_STOP;
            capstan_reverse <= 1'b0;
            head_near <= 1'b0;
        end else begin
            head_near <= wind && cue_reg; // head to tape in cue
            if (slow_reg) begin
                capstan_speed <= SPD_SIXTH;
            end else if (wind) begin
                capstan_speed <= cue_reg ? SPD_CUE : SPD_FAST; // third less
            end else if (mode_reg == M_PLAY || mode_reg == M_REC) begin
                capstan_speed <= SPD_NORMAL;
            end else begin
                capstan_speed <= SPD_STOP;
            end
            if (mode_reg == M_REW) begin
                capstan_reverse <= 1'b1;
            end else if (mode_reg == M_FFWD) begin
                capstan_reverse <= 1'b0;
            end else if (tape_rise && mode_reg == M_PLAY && ctrl_reg[CTRL_AREV_BIT]) begin
                capstan_reverse <= !capstan_reverse; // autoreverse flip
            end
        end
    end

    // bang-bang servo on control motor position
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cam_drive_en <= 1'b0;
            cam_drive_dir <= 1'b0;
        end else begin
            // one-step deadband: the registered drive lags a cycle, so a
            // zero band would overshoot and hunt around the set point
            cam_drive_en <= ({1'b0, cam_position} + 9'h001 < {1'b0, cam_goal})
                            || ({1'b0, cam_position} > {1'b0, cam_goal} + 9'h001);
            cam_drive_dir <= cam_position < cam_goal;
        end
    end

    // silence timer, reset by program above threshold
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            silence_reg <= 32'h00000000;
        end else if (mode_reg != M_REC || input_level > thresh_reg) begin
            silence_reg <= 32'h00000000;
        end else if (silence_reg < 32'(SILENCE_LIMIT)) begin
            silence_reg <= silence_reg + 32'h00000001;
        end
    end

    // signed display counter with clamps
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tape_counter <= 16'sd0;
        end else if (apb_wr && paddr == COUNT_OFF) begin
            tape_counter <= 16'sd0;
        end else if (counter_pulse) begin
            if (capstan_reverse && tape_counter > CNT_MIN) begin
                tape_counter <= tape_counter - 16'sd1;
            end else if (!capstan_reverse && tape_counter < CNT_MAX) begin
                tape_counter <= tape_counter + 16'sd1;
            end
        end
    end

    // record mute while key held, or toggled by remote
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            remote_mute_reg <= 1'b0;
            rec_mute <= 1'b0;
        end else begin
            if (mode_reg != M_REC) begin
                remote_mute_reg <= 1'b0;
            end else if (rec_tap_rem && !rem_play) begin
                remote_mute_reg <= !remote_mute_reg;
            end
            rec_mute <= key_mute || remote_mute_reg;
        end
    end

    // fade hold timer picks fast ramp
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            hold_reg <= 32'h00000000;
        end else if (!(key_fade_up || key_fade_down)) begin
            hold_reg <= 32'h00000000;
        end else if (hold_reg < 32'(HOLD_LIMIT)) begin
            hold_reg <= hold_reg + 32'h00000001;
        end
    end
    assign fade_fast = hold_reg >= 32'(HOLD_LIMIT);

    fade_ramp #(.SLOW_CYC(SLOW_CYC), .FAST_CYC(FAST_CYC)) u_fade (
        .clock(clock),
        .sys_rst(sys_rst),
        .start_up(key_fade_up && !prev_fade_reg),
        .start_down(key_fade_down && !prev_fade_reg),
        .fast(fade_fast),
        .gain(fade_gain),
        .busy(fade_busy)
    );

    // meter sensitivity and gain out
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            meter_boost_db <= 5'h00;
            rec_gain <= 8'hff;
        end else begin
            meter_boost_db <= ctrl_reg[CTRL_CAL_BIT] ? METER_BOOST_DB : 5'h00;
            rec_gain <= fade_gain;
        end
    end

    // apb register writes
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ctrl_reg <= CTRL_RST;
            thresh_reg <= THRESH_RST;
        end else if (apb_wr) begin
            if (paddr == CTRL_OFF) begin
                ctrl_reg <= pwdata[CTRL_W-1:0];
            end else if (paddr == THRESH_OFF) begin
                thresh_reg <= pwdata[15:0];
            end
        end
    end

    // apb reads, one wait state, error on unmapped
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
            pslverr <= !(paddr == CTRL_OFF || paddr == THRESH_OFF || paddr == COUNT_OFF
                         || paddr == STATUS_OFF || paddr == SERVO_OFF);
            unique case (paddr)
                CTRL_OFF: prdata <= {27'h0000000, ctrl_reg};
                THRESH_OFF: prdata <= {16'h0000, thresh_reg};
                COUNT_OFF: prdata <= {{16{tape_counter[15]}}, tape_counter};
                STATUS_OFF: prdata <= {18'h00000, rec_gain, fade_busy, rec_mute, cue_reg, mode_reg};
                SERVO_OFF: prdata <= {24'h000000, cam_position};
                default: prdata <= 32'h00000000;
            endcase
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // assertions
    a_silence_pause: assert property (@(posedge clock) disable iff (sys_rst)
        mode_reg == M_REC && ctrl_reg[CTRL_ARP_BIT] && silence_reg >= 32'(SILENCE_LIMIT) |=> mode_reg == M_PAUSE)
        else $error("no pause after silence");
    a_cue_speed: assert property (@(posedge clock) disable iff (sys_rst)
        wind && cue_reg && !slow_reg |=> capstan_speed == SPD_CUE)
        else $error("cue speed wrong");
    a_sixth_speed: assert property (@(posedge clock) disable iff (sys_rst)
        slow_reg |=> capstan_speed == SPD_SIXTH)
        else $error("sixth speed missing");
    a_memory_stop: assert property (@(posedge clock) disable iff (sys_rst)
        wind && ctrl_reg[CTRL_MEM_BIT] && at_zero && !(mode_reg == M_REC)
        |=> mode_reg == (ctrl_reg[CTRL_MEMPLAY_BIT] ? M_PLAY : M_STOP))
        else $error("memory stop missed");
    a_mute_held: assert property (@(posedge clock) disable iff (sys_rst)
        key_mute |=> rec_mute)
        else $error("mute not applied");
    a_meter_cal: assert property (@(posedge clock) disable iff (sys_rst)
        ctrl_reg[CTRL_CAL_BIT] |=> meter_boost_db == 5'h14)
        else $error("meter boost wrong");
    a_servo_stop: assert property (@(posedge clock) disable iff (sys_rst)
        cam_position == cam_target(mode_reg, cue_reg) && $stable(mode_reg) && $stable(cue_reg)
        |=> !cam_drive_en)
        else $error("servo runs at target");
    a_counter_span: assert property (@(posedge clock) disable iff (sys_rst)
        tape_counter >= CNT_MIN && tape_counter <= CNT_MAX)
        else $error("counter out of span");
    a_silence_restart: assert property (@(posedge clock) disable iff (sys_rst)
        input_level > thresh_reg |=> silence_reg == 32'h00000000)
        else $error("silence timer not restarted");
    c_punch_in: cover property (@(posedge clock) mode_reg == M_PLAY ##1 mode_reg == M_REC);
    c_cue_slow: cover property (@(posedge clock) cue_reg ##1 slow_reg);
    c_mem_play: cover property (@(posedge clock) mode_reg == M_FFWD ##1 mode_reg == M_PLAY);
    c_fade_run: cover property (@(posedge clock) $fell(fade_busy));
endmodule

// >>> verif/transport_partner.sv
// motor-side model: control motor position and tape counter pulses
`timescale 1ns/1ps
module transport_partner (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [3:0] capstan_speed,
    input wire logic cam_drive_en,
    input wire logic cam_drive_dir,
    output logic [7:0] cam_position,
    output logic counter_pulse
);
    logic [3:0] div_reg; // pulse divider
    // control motor moves one step a cycle while driven
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cam_position <= 8'h00;
        end else if (cam_drive_en) begin
            cam_position <= cam_drive_dir ? cam_position + 8'h01 : cam_position - 8'h01;
        end
    end
    // one counter pulse every eight cycles while tape moves
    always_ff @(posedge clock) begin
        if (sys_rst || capstan_speed == 4'h0) begin
            div_reg <= 4'h0;
            counter_pulse <= 1'b0;
        end else begin
            div_reg <= div_reg + 4'h1;
            counter_pulse <= (div_reg[2:0] == 3'h7);
        end
    end
endmodule

// >>> verif/tape_transport_mode_controller_bench.sv
// self-checking bench for the tape transport mode controller
`timescale 1ns/1ps
module tape_transport_mode_controller_bench;
    import transport_pkg::*;
    logic clock = 0; // 10 mhz clock
    logic sys_rst = 1; // sync reset
    logic psel = 0, penable = 0, pwrite = 0; // apb request
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, err;
    logic [12:0] keys = '0; // key levels
    logic tape_end = 0; // end of tape sense
    logic [15:0] input_level = '0; // program level
    logic [7:0] cam_position, rec_gain, prev;
    logic counter_pulse, capstan_reverse, cam_drive_en, cam_drive_dir, head_near, rec_mute, up_seen;
    logic [3:0] capstan_speed;
    logic [4:0] meter_boost_db;
    logic signed [15:0] tape_counter;
    int failures = 0, samples_checked = 0, c;
    localparam logic [12:0] PLAY = 13'h0001, REC = 13'h0002, STOP = 13'h0004, FFWD = 13'h0008, REW = 13'h0010;
    localparam logic [12:0] CUE = 13'h0020, FUP = 13'h0040, FDN = 13'h0080, MUTE = 13'h0100, RREC = 13'h0200;
    localparam logic [12:0] RPAUSE = 13'h0400, PAUSE = 13'h0800, RPLAY = 13'h1000;
    // free-running clock, 100 ns period
    always #50 clock = ~clock;
    transport_ctrl #(.SILENCE_LIMIT(50), .HOLD_LIMIT(5), .SLOW_CYC(4), .FAST_CYC(2)) i_dut (
        .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .key_play(keys[0]), .key_rec(keys[1]), .key_stop(keys[2]), .key_pause(keys[11]),
        .key_ffwd(keys[3]), .key_rew(keys[4]), .key_cue(keys[5]), .key_fade_up(keys[6]),
        .key_fade_down(keys[7]), .key_mute(keys[8]), .rem_play(keys[12]), .rem_rec(keys[9]),
        .rem_pause(keys[10]), .input_level(input_level), .counter_pulse(counter_pulse),
        .tape_end(tape_end), .cam_position(cam_position), .capstan_speed(capstan_speed),
        .capstan_reverse(capstan_reverse), .cam_drive_en(cam_drive_en), .cam_drive_dir(cam_drive_dir),
        .head_near(head_near), .rec_mute(rec_mute), .rec_gain(rec_gain),
        .meter_boost_db(meter_boost_db), .tape_counter(tape_counter));
    transport_partner i_motor (.clock(clock), .sys_rst(sys_rst), .capstan_speed(capstan_speed),
        .cam_drive_en(cam_drive_en), .cam_drive_dir(cam_drive_dir), .cam_position(cam_position),
        .counter_pulse(counter_pulse));
    // compare and count
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one apb transfer, waits for pready under a bound
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        check("pready", 1, n < 20);
    endtask
    // read mode field of status
    task automatic status(input logic [2:0] m);
        apb(0, STATUS_OFF, 0);
        check("mode", m, rd[2:0]);
    endtask
    // press keys together, hold, release, settle
    task automatic press(input logic [12:0] m, input int hold);
        @(posedge clock);
        keys <= keys | m;
        repeat (hold) @(posedge clock);
        keys <= keys & ~m;
        repeat (4) @(posedge clock);
    endtask
    task automatic t_regs();
        apb(0, THRESH_OFF, 0);
        check("thresh reset", 32'h100, rd);
        apb(0, CTRL_OFF, 0);
        check("ctrl reset", 0, rd);
        apb(1, 12'h040, 32'hffff);
        check("unmapped err", 1, err);
        apb(1, CTRL_OFF, 32'h8);
        repeat (3) @(posedge clock);
        check("meter boost", METER_BOOST_DB, meter_boost_db);
        apb(1, CTRL_OFF, 0);
        repeat (3) @(posedge clock);
        check("meter normal", 0, meter_boost_db);
    endtask
    task automatic t_record();
        press(PLAY | REC, 2);
        status(M_STOP);
        press(PLAY, 2);
        status(M_PLAY);
        press(PLAY | REC, 2);
        status(M_REC);
        check("punch speed", SPD_NORMAL, capstan_speed);
        @(posedge clock);
        keys <= keys | MUTE;
        repeat (6) @(posedge clock);
        check("mute held", 1, rec_mute);
        keys <= keys & ~MUTE;
        repeat (4) @(posedge clock);
        check("mute free", 0, rec_mute);
        press(RREC, 2);
        check("remote mute", 1, rec_mute);
        press(RREC, 2);
        check("remote unmute", 0, rec_mute);
        press(PAUSE, 2);
        status(M_PAUSE);
        press(RPLAY, 2);
        status(M_PLAY);
        press(RPLAY | RREC, 2);
        status(M_REC);
        check("punch no mute", 0, rec_mute);
    endtask
    task automatic t_silence();
        apb(1, CTRL_OFF, 32'h1);
        input_level <= 16'h0200;
        repeat (100) @(posedge clock);
        status(M_REC);
        input_level <= 16'h0000;
        c = 0;
        while (capstan_speed !== SPD_STOP && c < 200) begin
            @(posedge clock);
            c++;
        end
        check("silence span", 1, c >= 50 && c <= 60);
        status(M_PAUSE);
        apb(1, CTRL_OFF, 0);
    endtask
    task automatic t_fade();
        press(FUP, 1);
        c = 0;
        while (rec_gain !== 8'hff && c < 2000) begin
            @(posedge clock);
            c++;
        end
        check("tap fade span", 1, c >= 990 && c <= 1040);
        @(posedge clock);
        keys <= keys | FDN;
        c = 0;
        prev = 8'hff;
        up_seen = 0;
        while (rec_gain !== 8'h00 && c < 2000) begin
            @(posedge clock);
            up_seen = up_seen | (rec_gain > prev);
            prev = rec_gain;
            c++;
        end
        keys <= keys & ~FDN;
        check("held fade span", 1, c >= 500 && c <= 540);
        check("fade monotonic", 0, up_seen);
    endtask
    task automatic t_cue();
        press(STOP, 2);
        press(FFWD, 2);
        check("wind speed", SPD_FAST, capstan_speed);
        press(CUE, 2);
        check("cue speed", SPD_CUE, capstan_speed);
        check("cue head", 1, head_near);
        @(posedge clock);
        keys <= keys | FFWD;
        repeat (5) @(posedge clock);
        check("sixth speed", SPD_SIXTH, capstan_speed);
        keys <= keys & ~FFWD;
        repeat (5) @(posedge clock);
        check("cue again", SPD_CUE, capstan_speed);
        press(STOP, 2);
        press(REW, 2);
        press(RPAUSE, 2);
        check("remote cue", SPD_CUE, capstan_speed);
        check("remote cue head", 1, head_near);
    endtask
    task automatic t_memory(input logic play);
        apb(1, CTRL_OFF, 0);
        press(STOP, 2);
        apb(1, COUNT_OFF, 0);
        press(FFWD, 2);
        repeat (60) @(posedge clock);
        press(STOP, 2);
        apb(1, CTRL_OFF, play ? 32'h6 : 32'h2);
        press(REW, 2);
        c = 0;
        while (tape_counter !== 16'sd0 && c < 400) begin
            @(posedge clock);
            c++;
        end
        check("memory reached", 1, c < 400);
        repeat (4) @(posedge clock);
        status(play ? M_PLAY : M_STOP);
        check("memory speed", play ? SPD_NORMAL : SPD_STOP, capstan_speed);
    endtask
    // servo settles, held end of tape reverses once or stops
    task automatic t_reverse();
        repeat (200) @(posedge clock);
        apb(0, SERVO_OFF, 0);
        check("cam position", 8'hc0, rd[7:0]);
        check("cam drive idle", 0, cam_drive_en);
        apb(1, CTRL_OFF, 32'h10);
        @(posedge clock);
        tape_end <= 1;
        repeat (2) @(posedge clock);
        tape_end <= 0;
        repeat (3) @(posedge clock);
        check("auto reverse", 0, capstan_reverse);
        status(M_PLAY);
        apb(1, CTRL_OFF, 0);
        @(posedge clock);
        tape_end <= 1;
        repeat (3) @(posedge clock);
        tape_end <= 0;
        status(M_STOP);
    endtask
    // verdict and end of run
    task automatic print_verdict();
        if (failures == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (10) @(posedge clock);
        sys_rst <= 0;
        check("gain reset", 8'hff, rec_gain);
        t_regs();
        t_record();
        t_silence();
        t_fade();
        t_cue();
        t_memory(0);
        t_memory(1);
        t_reverse();
        print_verdict();
    end
    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        print_verdict();
    end
endmodule
